// ---- hdl/probe_pkg.sv ----
package probe_pkg;

   // ------------------------------------------------------------
   // register offsets (byte addresses, one word each)
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_IN_VALUE = 8'h00;
   localparam logic [7:0] OFF_ACTIVITY = 8'h04;
   localparam logic [7:0] OFF_SYNC_SEL = 8'h08;
   localparam logic [7:0] OFF_OUT_STATIC = 8'h0c;
   localparam logic [7:0] OFF_TOGGLE = 8'h10;
   localparam logic [7:0] OFF_BTN_EN = 8'h14;
   localparam logic [7:0] OFF_BTN_POL = 8'h18;
   localparam logic [7:0] OFF_BTN_PRESS = 8'h1c;
   localparam logic [7:0] OFF_TRAIN_EN = 8'h20;
   localparam logic [7:0] OFF_COMMAND = 8'h24;
   localparam logic [7:0] OFF_PULSE = 8'h28;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h2c;
   localparam logic [7:0] OFF_IRQ_CLEAR = 8'h30;
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'h34;
   localparam logic [7:0] OFF_TRAIN_BASE = 8'h40;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int unsigned ACT_ARISE_POS = 0;
   localparam int unsigned ACT_AFALL_POS = 8;
   localparam int unsigned ACT_SRISE_POS = 16;
   localparam int unsigned ACT_SFALL_POS = 24;
   localparam int unsigned CMD_RUN_BIT = 0;
   localparam int unsigned CMD_RESET_OUT_BIT = 1;
   localparam int unsigned CMD_CLEAR_ACT_BIT = 2;
   localparam int unsigned IRQ_ACT_BIT = 0;
   localparam int unsigned IRQ_DONE_BIT = 1;
   localparam int unsigned IRQ_W = 2;
   localparam int unsigned TRAIN_LEN = 16;
   localparam logic [3:0] TRAIN_LAST = 4'hf;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef enum logic {TR_IDLE, TR_PLAY} train_state_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } bus_req_t;

endpackage : probe_pkg

// ---- hdl/pin_sync.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------
// three-stage pin synchroniser
// ------------------------------------------------------------
module pin_sync #(
   parameter int unsigned W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end
      else
      begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a bit rises only once stages two and three agree high; it clears as soon as they differ
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         dout <= '0;
      else
         dout <= (dout & ~(s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
   end

endmodule : pin_sync

// ---- hdl/probe_core.sv ----
`timescale 1ns/1ps

// Function
// RULE_01: each input returns present value plus activity since previous host read.
// RULE_02: synchronous inputs also detect transitions sampled on the design clock.
// RULE_03: separate rise and fall indications; both may be set together.
// RULE_04: clocked and unclocked activity are kept and reported apart.
// RULE_05: push button drives inactive level, active level only while pressed.
// RULE_06: each toggle command flips the output between one and zero.
// RULE_07: sixteen-step per-bit pulse sequence on design-clock cycles.
// RULE_08: run command plays the stored sequence exactly once, no repeat.
// RULE_09: single pulse gives exactly one high design-clock cycle.
// RULE_10: host polls inputs periodically, default 250 ms, selectable intervals.
// RULE_11: in manual mode host reads inputs only on sample-once request.
// RULE_12: host sends changed outputs at once, or all static outputs together.
// RULE_13: reset-all returns static and toggle outputs and sequences to zero.
// RULE_14: clear-all-activity resets every input activity record.
// RULE_15: reading the activity record clears it for later transitions.
module probe_core #(
   parameter int unsigned N_IN = 8,
   parameter int unsigned N_OUT = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic design_clk,
   input wire logic [N_IN-1:0] probe_in,
   output logic [N_OUT-1:0] probe_out,
   output logic irq
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic is_train(input logic [7:0] a);
      is_train = (a[7:6] == probe_pkg::OFF_TRAIN_BASE[7:6]);
   endfunction : is_train

   function automatic logic [7:0] wide8(input logic [N_IN-1:0] v);
      wide8 = 8'(v);
   endfunction : wide8

   // ------------------------------------------------------------
   // pin sampling and design-clock edge
   // ------------------------------------------------------------
   logic [N_IN-1:0] in_now;
   logic dclk_now;
   logic dclk_prev_q;
   logic dclk_rise;

   pin_sync #(.W(N_IN)) u_in_sync (
      .clk(hclk),
      .rst_n(hresetn),
      .din(probe_in),
      .dout(in_now)
   );

   pin_sync #(.W(1)) u_dclk_sync (
      .clk(hclk),
      .rst_n(hresetn),
      .din(design_clk),
      .dout(dclk_now)
   );

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         dclk_prev_q <= 1'b0;
      else
         dclk_prev_q <= dclk_now;
   end

   assign dclk_rise = dclk_now & ~dclk_prev_q;

   // ------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------
   probe_pkg::bus_req_t req_q;
   logic take;
   logic wr_en;
   logic act_read;
   logic [31:0] rd_mux;

   // single-word transfers only; hsize is not checked
   assign take = hsel & htrans[1] & hready;
   assign wr_en = req_q.valid & req_q.write;
   assign act_read = take & ~hwrite & (haddr[7:0] == probe_pkg::OFF_ACTIVITY);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         req_q <= '0;
      else
      begin
         req_q.valid <= take;
         req_q.write <= hwrite;
         req_q.addr <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   logic wr_sync_sel;
   logic wr_static;
   logic wr_toggle;
   logic wr_btn_en;
   logic wr_btn_pol;
   logic wr_btn_press;
   logic wr_train_en;
   logic wr_cmd;
   logic wr_pulse;
   logic wr_irq_clr;
   logic wr_irq_en;
   logic run_cmd;
   logic reset_cmd;
   logic clear_cmd;

   assign wr_sync_sel = wr_en & (req_q.addr == probe_pkg::OFF_SYNC_SEL);
   assign wr_static = wr_en & (req_q.addr == probe_pkg::OFF_OUT_STATIC);
   assign wr_toggle = wr_en & (req_q.addr == probe_pkg::OFF_TOGGLE);
   assign wr_btn_en = wr_en & (req_q.addr == probe_pkg::OFF_BTN_EN);
   assign wr_btn_pol = wr_en & (req_q.addr == probe_pkg::OFF_BTN_POL);
   assign wr_btn_press = wr_en & (req_q.addr == probe_pkg::OFF_BTN_PRESS);
   assign wr_train_en = wr_en & (req_q.addr == probe_pkg::OFF_TRAIN_EN);
   assign wr_cmd = wr_en & (req_q.addr == probe_pkg::OFF_COMMAND);
   assign wr_pulse = wr_en & (req_q.addr == probe_pkg::OFF_PULSE);
   assign wr_irq_clr = wr_en & (req_q.addr == probe_pkg::OFF_IRQ_CLEAR);
   assign wr_irq_en = wr_en & (req_q.addr == probe_pkg::OFF_IRQ_ENABLE);
   assign run_cmd = wr_cmd & hwdata[probe_pkg::CMD_RUN_BIT];
   assign reset_cmd = wr_cmd & hwdata[probe_pkg::CMD_RESET_OUT_BIT];
   assign clear_cmd = wr_cmd & hwdata[probe_pkg::CMD_CLEAR_ACT_BIT];

   // ------------------------------------------------------------
   // input activity
   // ------------------------------------------------------------
   logic [N_IN-1:0] in_prev_q;
   logic [N_IN-1:0] samp_q;
   logic [N_IN-1:0] sync_sel_q;
   logic [N_IN-1:0] arise_q, afall_q, srise_q, sfall_q;
   logic [N_IN-1:0] arise_set, afall_set, srise_set, sfall_set;
   logic clr_act;

   assign arise_set = in_now & ~in_prev_q; // [RULE_03]
   assign afall_set = ~in_now & in_prev_q; // [RULE_03]
   // clocked detection only on inputs marked synchronous
   assign srise_set = {N_IN{dclk_rise}} & sync_sel_q & in_now & ~samp_q; // [RULE_02]
   assign sfall_set = {N_IN{dclk_rise}} & sync_sel_q & ~in_now & samp_q; // [RULE_02]
   assign clr_act = act_read | clear_cmd; // [RULE_14] [RULE_15]

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         in_prev_q <= '0;
         samp_q <= '0;
      end
      else
      begin
         in_prev_q <= in_now;
         if (dclk_rise)
            samp_q <= in_now;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         sync_sel_q <= '0;
      else if (wr_sync_sel)
         sync_sel_q <= hwdata[N_IN-1:0];
   end

   // a transition in the clearing cycle survives the clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         arise_q <= '0;
         afall_q <= '0;
         srise_q <= '0;
         sfall_q <= '0;
      end
      else
      begin
         arise_q <= (arise_q & ~{N_IN{clr_act}}) | arise_set; // [RULE_04] [RULE_15]
         afall_q <= (afall_q & ~{N_IN{clr_act}}) | afall_set; // [RULE_04] [RULE_15]
         srise_q <= (srise_q & ~{N_IN{clr_act}}) | srise_set; // [RULE_04] [RULE_14]
         sfall_q <= (sfall_q & ~{N_IN{clr_act}}) | sfall_set; // [RULE_04] [RULE_14]
      end
   end

   // ------------------------------------------------------------
   // outputs: static, toggle, push button
   // ------------------------------------------------------------
   logic [N_OUT-1:0] static_q;
   logic [N_OUT-1:0] btn_en_q, btn_pol_q, btn_press_q;
   logic [N_OUT-1:0] train_en_q;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         static_q <= '0;
      else if (reset_cmd)
         static_q <= '0; // [RULE_13]
      else if (wr_static)
         static_q <= hwdata[N_OUT-1:0];
      else if (wr_toggle)
         static_q <= static_q ^ hwdata[N_OUT-1:0]; // [RULE_06]
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         btn_en_q <= '0;
         btn_pol_q <= '0;
         btn_press_q <= '0;
         train_en_q <= '0;
      end
      else
      begin
         if (wr_btn_en)
            btn_en_q <= hwdata[N_OUT-1:0];
         if (wr_btn_pol)
            btn_pol_q <= hwdata[N_OUT-1:0];
         if (wr_btn_press)
            btn_press_q <= hwdata[N_OUT-1:0];
         if (wr_train_en)
            train_en_q <= hwdata[N_OUT-1:0];
      end
   end

   // ------------------------------------------------------------
   // pulse sequence and single pulse
   // ------------------------------------------------------------
   logic [N_OUT-1:0] train_mem_q [probe_pkg::TRAIN_LEN];
   logic [N_OUT-1:0] train_out_q;
   logic [N_OUT-1:0] pulse_pend_q, pulse_live_q;
   probe_pkg::train_state_t tr_state_q;
   logic [3:0] step_q;
   logic train_done;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < probe_pkg::TRAIN_LEN; i++)
            train_mem_q[i] <= '0;
      end
      else if (reset_cmd)
      begin
         for (int i = 0; i < probe_pkg::TRAIN_LEN; i++)
            train_mem_q[i] <= '0; // [RULE_13]
      end
      else if (wr_en && is_train(req_q.addr))
         train_mem_q[req_q.addr[5:2]] <= hwdata[N_OUT-1:0]; // [RULE_07]
   end

   // one step per design-clock rise; a run during play is ignored
   assign train_done = (tr_state_q == probe_pkg::TR_PLAY) && dclk_rise
                       && (step_q == probe_pkg::TRAIN_LAST);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tr_state_q <= probe_pkg::TR_IDLE;
         step_q <= '0;
         train_out_q <= '0;
      end
      else if (reset_cmd)
      begin
         tr_state_q <= probe_pkg::TR_IDLE;
         step_q <= '0;
         train_out_q <= '0; // [RULE_13]
      end
      else
      begin
         unique case (tr_state_q)
            probe_pkg::TR_IDLE:
               if (run_cmd)
               begin
                  tr_state_q <= probe_pkg::TR_PLAY; // [RULE_08]
                  step_q <= '0;
               end
            probe_pkg::TR_PLAY:
               if (dclk_rise)
               begin
                  train_out_q <= train_mem_q[step_q]; // [RULE_07]
                  step_q <= step_q + 4'h1;
                  if (train_done)
                     tr_state_q <= probe_pkg::TR_IDLE; // [RULE_08]
               end
         endcase
      end
   end

   // request waits for a design-clock rise, lives one design cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pulse_pend_q <= '0;
         pulse_live_q <= '0;
      end
      else
      begin
         if (wr_pulse)
            pulse_pend_q <= (dclk_rise ? '0 : pulse_pend_q) | hwdata[N_OUT-1:0];
         else if (dclk_rise)
            pulse_pend_q <= '0;
         if (dclk_rise)
            pulse_live_q <= pulse_pend_q; // [RULE_09]
      end
   end

   // ------------------------------------------------------------
   // output mux, registered
   // ------------------------------------------------------------
   logic [N_OUT-1:0] out_d;

   always_comb
   begin
      out_d = static_q;
      out_d = (out_d & ~btn_en_q) | (btn_en_q & (btn_pol_q ^ btn_press_q)); // [RULE_05]
      out_d = (out_d & ~train_en_q) | (train_en_q & train_out_q);
      out_d = out_d | pulse_live_q; // [RULE_09]
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         probe_out <= '0;
      else
         probe_out <= out_d;
   end

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   logic [probe_pkg::IRQ_W-1:0] irq_stat_q, irq_en_q, irq_set, irq_stat_d;

   assign irq_set = {train_done, |{arise_set, afall_set, srise_set, sfall_set}};

   always_comb
   begin
      irq_stat_d = irq_stat_q;
      if (wr_irq_clr)
         irq_stat_d = irq_stat_q & ~hwdata[probe_pkg::IRQ_W-1:0];
      irq_stat_d = irq_stat_d | irq_set;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_stat_q <= '0;
         irq_en_q <= '0;
         irq <= 1'b0;
      end
      else
      begin
         irq_stat_q <= irq_stat_d;
         if (wr_irq_en)
            irq_en_q <= hwdata[probe_pkg::IRQ_W-1:0];
         irq <= |(irq_stat_d & (wr_irq_en ? hwdata[probe_pkg::IRQ_W-1:0] : irq_en_q));
      end
   end

   // ------------------------------------------------------------
   // read data, captured in the address phase
   // ------------------------------------------------------------
   always_comb
   begin
      rd_mux = probe_pkg::RST_WORD;
      if (is_train(haddr[7:0]))
         rd_mux = 32'(train_mem_q[haddr[5:2]]);
      else
      begin
         unique case (haddr[7:0])
            probe_pkg::OFF_IN_VALUE: rd_mux = 32'(in_now); // [RULE_01]
            probe_pkg::OFF_ACTIVITY:
               rd_mux = {wide8(sfall_q), wide8(srise_q), wide8(afall_q), wide8(arise_q)};
            probe_pkg::OFF_SYNC_SEL: rd_mux = 32'(sync_sel_q);
            probe_pkg::OFF_OUT_STATIC: rd_mux = 32'(static_q);
            probe_pkg::OFF_BTN_EN: rd_mux = 32'(btn_en_q);
            probe_pkg::OFF_BTN_POL: rd_mux = 32'(btn_pol_q);
            probe_pkg::OFF_BTN_PRESS: rd_mux = 32'(btn_press_q);
            probe_pkg::OFF_TRAIN_EN: rd_mux = 32'(train_en_q);
            probe_pkg::OFF_IRQ_STATUS: rd_mux = 32'(irq_stat_q);
            probe_pkg::OFF_IRQ_ENABLE: rd_mux = 32'(irq_en_q);
            default: rd_mux = probe_pkg::RST_WORD;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= probe_pkg::RST_WORD;
      else if (take && !hwrite)
         hrdata <= rd_mux; // [RULE_01]
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   in_value_a: assert property ( // [RULE_01]
      @(posedge hclk) disable iff (!hresetn)
      take && !hwrite && haddr[7:0] == probe_pkg::OFF_IN_VALUE
      |=> hrdata == 32'($past(in_now)))
      else $error("input value read mismatch");

   rise_fall_a: assert property ( // [RULE_03]
      @(posedge hclk) disable iff (!hresetn)
      in_now[0] != in_prev_q[0] |=> (in_prev_q[0] ? arise_q[0] : afall_q[0]))
      else $error("transition not recorded");

   sync_detect_a: assert property ( // [RULE_02]
      @(posedge hclk) disable iff (!hresetn)
      dclk_rise && sync_sel_q[0] && in_now[0] && !samp_q[0] |=> srise_q[0])
      else $error("clocked rise missed");

   sync_only_a: assert property ( // [RULE_04]
      @(posedge hclk) disable iff (!hresetn)
      $rose(srise_q[0]) |-> $past(sync_sel_q[0]) && $past(dclk_rise))
      else $error("clocked activity on unclocked input");

   button_a: assert property ( // [RULE_05]
      @(posedge hclk) disable iff (!hresetn)
      btn_en_q[0] && !train_en_q[0] && !pulse_live_q[0]
      |=> probe_out[0] == $past(btn_pol_q[0] ^ btn_press_q[0]))
      else $error("push button level wrong");

   toggle_flip_a: assert property ( // [RULE_06]
      @(posedge hclk) disable iff (!hresetn)
      wr_toggle && hwdata[0] && !reset_cmd |=> static_q[0] != $past(static_q[0]))
      else $error("toggle did not flip");

   train_end_a: assert property ( // [RULE_07]
      @(posedge hclk) disable iff (!hresetn)
      train_done |=> tr_state_q == probe_pkg::TR_IDLE && step_q == 4'h0)
      else $error("sequence length wrong");

   no_repeat_a: assert property ( // [RULE_08]
      @(posedge hclk) disable iff (!hresetn)
      tr_state_q == probe_pkg::TR_IDLE && !run_cmd |=> tr_state_q == probe_pkg::TR_IDLE)
      else $error("sequence replayed without run");

   pulse_end_a: assert property ( // [RULE_09]
      @(posedge hclk) disable iff (!hresetn)
      dclk_rise && !pulse_pend_q[0]
      |=> !pulse_live_q[0] ##1
      (!probe_out[0] || $past(static_q[0] | btn_en_q[0] | train_en_q[0])))
      else $error("single pulse too long");

   reset_all_a: assert property ( // [RULE_13]
      @(posedge hclk) disable iff (!hresetn)
      reset_cmd |=> static_q == '0 && train_out_q == '0 && train_mem_q[0] == '0)
      else $error("outputs not reset");

   clear_act_a: assert property ( // [RULE_14]
      @(posedge hclk) disable iff (!hresetn)
      clr_act && in_now == in_prev_q && !dclk_rise
      |=> arise_q == '0 && afall_q == '0 && srise_q == '0 && sfall_q == '0)
      else $error("activity not cleared");

endmodule : probe_core

// ---- tb/user_logic_model.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------
// user logic beside the probe
// ------------------------------------------------------------
module user_logic_model (
   input wire logic [7:0] level,
   output logic design_clk,
   output logic [7:0] probe_in
);
   // odd offset keeps the user clock out of phase with hclk
   initial
   begin
      design_clk = 1'b0;
      probe_in = 8'h00;
      #3;
      forever #80 design_clk = ~design_clk;
   end

   // registered source: signals move only on the user clock
   always @(posedge design_clk)
   begin
      probe_in <= level;
   end
endmodule : user_logic_model

// ---- tb/test_virtual_io_probe.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("unexpected %s: expected %h seen %h", nm, e, g); end end

// ------------------------------------------------------------
// bench for the probe core
// ------------------------------------------------------------
module test_virtual_io_probe;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, design_clk;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] probe_in, probe_out, level;
   int errors, total_checks, n, k;
   typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_t;
   row_t rows [6];

   probe_core u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .design_clk(design_clk), .probe_in(probe_in), .probe_out(probe_out), .irq(irq));
   user_logic_model u_user (.level(level), .design_clk(design_clk), .probe_in(probe_in));

   initial
   begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : bus

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      `CHK($sformatf("read %h", a), e, rd)
   endtask : rchk

   // outputs are registered one hclk behind their controlling register
   task automatic out_chk(input logic [7:0] e);
      repeat (2) @(posedge hclk);
      `CHK("probe_out", e, probe_out)
      `CHK("ready and okay", 2'b10, {hreadyout, hresp})
   endtask : out_chk

   // three user clocks: the change is surely seen at a detected rise
   task automatic wait_user(input logic [7:0] v);
      level <= v;
      repeat (3) @(posedge design_clk);
      repeat (6) @(posedge hclk);
   endtask : wait_user

   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done

   initial
   begin
      repeat (10000) @(posedge hclk);
      errors++;
      test_done();
   end

   initial
   begin
      {hresetn, hsel, haddr, htrans, hwrite, hwdata, level} = '0;
      hsize = 3'h2;
      errors = 0;
      total_checks = 0;
      rows = '{'{probe_pkg::OFF_SYNC_SEL, 32'hff, 32'hff},
         '{probe_pkg::OFF_OUT_STATIC, 32'hffff_ffa5, 32'ha5},
         '{probe_pkg::OFF_IRQ_ENABLE, 32'h3, 32'h3},
         '{probe_pkg::OFF_TRAIN_BASE, 32'hff, 32'hff},
         '{8'h7c, 32'hc3, 32'hc3},
         '{8'h38, 32'hff, 32'h0}};
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      `CHK("reset outputs", 11'h002, {probe_out, irq, hreadyout, hresp})
      foreach (rows[i])
      begin
         bus(1'b1, rows[i].a, rows[i].w);
         rchk(rows[i].a, rows[i].e);
      end
      out_chk(8'ha5);
      bus(1'b1, probe_pkg::OFF_TOGGLE, 32'h0f);
      out_chk(8'haa);
      bus(1'b1, probe_pkg::OFF_TOGGLE, 32'h0f);
      out_chk(8'ha5);
      bus(1'b1, probe_pkg::OFF_OUT_STATIC, 32'h0);
      bus(1'b1, probe_pkg::OFF_BTN_POL, 32'h1);
      bus(1'b1, probe_pkg::OFF_BTN_EN, 32'h1);
      out_chk(8'h01);
      for (k = 0; k < 4; k++)
      begin
         if (k == 2)
            bus(1'b1, probe_pkg::OFF_BTN_POL, 32'h0);
         bus(1'b1, probe_pkg::OFF_BTN_PRESS, 32'(~k & 1));
         out_chk(8'(k[1] ^ k[0]));
      end
      bus(1'b1, probe_pkg::OFF_BTN_EN, 32'h0);
      // manual sampling: the bench reads only when it chooses to
      wait_user(8'h01);
      rchk(probe_pkg::OFF_IN_VALUE, 32'h1);
      // periodic polling, interval scaled down to bench time
      for (k = 0; k < 3; k++)
      begin
         repeat (20) @(posedge hclk);
         rchk(probe_pkg::OFF_IN_VALUE, 32'h1);
      end
      rchk(probe_pkg::OFF_ACTIVITY, 32'h0001_0001);
      rchk(probe_pkg::OFF_ACTIVITY, 32'h0);
      `CHK("irq", 1'b1, irq)
      bus(1'b1, probe_pkg::OFF_IRQ_ENABLE, 32'h0);
      repeat (2) @(posedge hclk);
      `CHK("irq masked", 1'b0, irq)
      bus(1'b1, probe_pkg::OFF_IRQ_ENABLE, 32'h3);
      bus(1'b1, probe_pkg::OFF_IRQ_CLEAR, 32'h3);
      rchk(probe_pkg::OFF_IRQ_STATUS, 32'h0);
      `CHK("irq cleared", 1'b0, irq)
      wait_user(8'h03);
      wait_user(8'h01);
      rchk(probe_pkg::OFF_ACTIVITY, 32'h0202_0202);
      bus(1'b1, probe_pkg::OFF_SYNC_SEL, 32'h0);
      wait_user(8'h05);
      rchk(probe_pkg::OFF_ACTIVITY, 32'h0000_0004);
      wait_user(8'h00);
      bus(1'b1, probe_pkg::OFF_COMMAND, 32'h4);
      rchk(probe_pkg::OFF_ACTIVITY, 32'h0);
      bus(1'b1, probe_pkg::OFF_IRQ_CLEAR, 32'h3);
      for (k = 0; k < 16; k++)
         bus(1'b1, probe_pkg::OFF_TRAIN_BASE + 8'(4 * k), 32'(k + 1));
      bus(1'b1, probe_pkg::OFF_OUT_STATIC, 32'h3c);
      bus(1'b1, probe_pkg::OFF_TRAIN_EN, 32'hff);
      bus(1'b1, probe_pkg::OFF_COMMAND, 32'h1);
      n = 0;
      do
      begin
         @(negedge design_clk);
         n++;
      end while (probe_out !== 8'h01 && n < 4);
      `CHK("first step", 8'h01, probe_out)
      for (k = 2; k < 19; k++)
      begin
         @(negedge design_clk);
         `CHK("sequence step", 8'(k > 16 ? 16 : k), probe_out)
      end
      rchk(probe_pkg::OFF_IRQ_STATUS, 32'h2);
      bus(1'b1, probe_pkg::OFF_COMMAND, 32'h2);
      out_chk(8'h00);
      rchk(probe_pkg::OFF_TRAIN_BASE + 8'h3c, 32'h0);
      rchk(probe_pkg::OFF_OUT_STATIC, 32'h0);
      bus(1'b1, probe_pkg::OFF_TRAIN_EN, 32'h0);
      bus(1'b1, probe_pkg::OFF_PULSE, 32'h81);
      // a second pulse or a held level would give 40 or more
      n = 0;
      repeat (100)
      begin
         @(posedge hclk);
         n += (probe_out === 8'h81);
      end
      `CHK("pulse cycles", 20, n)
      bus(1'b1, probe_pkg::OFF_OUT_STATIC, 32'h0f);
      @(posedge hclk);
      hresetn <= 1'b0;
      @(posedge hclk);
      `CHK("reset outputs", 11'h002, {probe_out, irq, hreadyout, hresp})
      hresetn <= 1'b1;
      rchk(probe_pkg::OFF_OUT_STATIC, 32'h0);
      test_done();
   end
endmodule : test_virtual_io_probe
